// *** verilog/pachg_defines.vh ***
`ifndef PACHG_DEFINES_VH
`define PACHG_DEFINES_VH
`define PACHG_ADDR_W        4
`define PACHG_A_PINS        4'h0
`define PACHG_A_LATCH       4'h1
`define PACHG_A_DIR         4'h2
`define PACHG_A_CHG_EN      4'h3
`define PACHG_A_PULLUP      4'h4
`define PACHG_A_ANALOG      4'h5
`define PACHG_A_INTCTL      4'h6
`define PACHG_A_INTCTL2     4'h7
`define PACHG_A_SERBUS      4'h8
`define PACHG_DIR_RST       8'h30
`define PACHG_LATCH_RST     8'h00
`define PACHG_CHG_EN_RST    8'h00
`define PACHG_PULLUP_RST    8'h00
`define PACHG_ANALOG_RST    8'h08
`define PACHG_PIN_MASK      8'h3b
`define PACHG_IO_MASK       8'h30
`define PACHG_PULLUP_MASK   8'h3b
`define PACHG_ANALOG_MASK   8'hf8
`define PACHG_BIT_ANS_PIN4  3
`define PACHG_BIT_FLAG      0
`define PACHG_BIT_GLOBAL_EN 3
`define PACHG_BIT_PRIO      0
`define PACHG_BIT_PU_DIS    7
`define PACHG_BIT_SERBUS    3
`endif

// *** verilog/pachg_sync.v ***
`timescale 1ns/100ps
`default_nettype none
module pachg_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage_reg;

  // First stage feeds only the second
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      stage_reg <= {WIDTH{1'b0}};
      sync_out  <= {WIDTH{1'b0}};
    end else begin
      stage_reg <= async_in;
      sync_out  <= stage_reg;
    end
  end
endmodule
`default_nettype wire

// *** verilog/pachg_detect.v ***
`timescale 1ns/100ps
`default_nettype none
module pachg_detect #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             por_n,
  input  wire [WIDTH-1:0] pins_sync,
  input  wire [WIDTH-1:0] watch,
  input  wire             capture,
  output wire             mismatch
);
  reg [WIDTH-1:0] last_read_reg;

  // Only power-on clears the copy; other resets keep it
  always @(posedge clk_sys) begin
    if (!por_n) begin
      last_read_reg <= {WIDTH{1'b0}};
    end else if (capture) begin
      last_read_reg <= pins_sync;
    end
  end

  assign mismatch = |((pins_sync ^ last_read_reg) & watch);
endmodule
`default_nettype wire

// *** verilog/pachg_port.v ***
// Strobed register access and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "pachg_defines.vh"
module pachg_port #(
  parameter WIDTH = 8
) (
  input  wire                     clk_sys,
  input  wire                     rst_n,
  input  wire                     por_n,
  input  wire [`PACHG_ADDR_W-1:0] reg_addr,
  input  wire [WIDTH-1:0]         reg_wdata,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  input  wire                     move_instr,
  output reg  [WIDTH-1:0]         reg_rdata,
  input  wire [WIDTH-1:0]         pin_in,
  output reg  [WIDTH-1:0]         pin_out,
  output reg  [WIDTH-1:0]         pin_oe,
  output reg  [WIDTH-1:0]         pin_pullup,
  output reg                      pin4_analog,
  input  wire                     master_clear_enable_cfg,
  input  wire                     osc_uses_pins,
  input  wire                     second_port_mismatch,
  output reg                      pin_change_flag,
  output reg                      pin_change_irq,
  output reg                      pin_change_priority,
  output reg                      wake_request,
  output reg                      serial_bus_module_enable
);
  reg  [WIDTH-1:0] latch_reg;
  reg  [WIDTH-1:0] dir_reg;
  reg  [WIDTH-1:0] chg_en_reg;
  reg  [WIDTH-1:0] pullup_reg;
  reg  [WIDTH-1:0] analog_reg;
  reg              global_en_reg;
  reg              pu_dis_reg;
  reg  [WIDTH-1:0] rdata_next;
  reg  [WIDTH-1:0] avail;
  reg  [WIDTH-1:0] watch;
  wire [WIDTH-1:0] pins_sync;
  wire             mismatch;
  wire             port_touch;
  wire             flag_clear;

  function sel;
    input [`PACHG_ADDR_W-1:0] a;
    input [`PACHG_ADDR_W-1:0] b;
    begin
      sel = (a == b);
    end
  endfunction

  pachg_sync #(.WIDTH(WIDTH)) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (pin_in),
    .sync_out (pins_sync)
  );

  // Available digital pins per mode
  always @* begin
    avail = `PACHG_PIN_MASK;
    if (osc_uses_pins) begin
      avail[5] = 1'b0;
      avail[4] = 1'b0;
    end
    if (analog_reg[`PACHG_BIT_ANS_PIN4]) begin
      avail[4] = 1'b0;
    end
    if (master_clear_enable_cfg) begin
      avail[3] = 1'b0;
    end
    if (serial_bus_module_enable || (chg_en_reg[1:0] != 2'b11)) begin
      avail[1:0] = 2'b00;
    end
  end

  // Inputs only, enabled, and bus pins dropped while bus runs
  always @* begin
    watch = chg_en_reg & ~(~dir_reg & `PACHG_IO_MASK) & `PACHG_PIN_MASK;
    if (serial_bus_module_enable) begin
      watch[1:0] = 2'b00;
    end
    if (osc_uses_pins) begin
      watch[5:4] = 2'b00;
    end
  end

  // Any non-move port access ends mismatch; a watched change at the access is still flagged
  assign port_touch = (reg_rd || reg_wr) && sel(reg_addr, `PACHG_A_PINS)
                      && !move_instr;

  pachg_detect #(.WIDTH(WIDTH)) u_detect (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .por_n     (por_n),
    .pins_sync (pins_sync),
    .watch     (watch),
    .capture   (port_touch),
    .mismatch  (mismatch)
  );

  assign flag_clear = reg_wr && sel(reg_addr, `PACHG_A_INTCTL)
                      && !reg_wdata[`PACHG_BIT_FLAG];

  // Registers
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      latch_reg                <= `PACHG_LATCH_RST;
      dir_reg                  <= `PACHG_DIR_RST;
      chg_en_reg               <= `PACHG_CHG_EN_RST;
      analog_reg               <= `PACHG_ANALOG_RST;
      global_en_reg            <= 1'b0;
      pin_change_priority      <= 1'b1;
      serial_bus_module_enable <= 1'b0;
    end else if (reg_wr) begin
      if (sel(reg_addr, `PACHG_A_PINS) || sel(reg_addr, `PACHG_A_LATCH)) begin
        latch_reg <= reg_wdata & `PACHG_IO_MASK;
      end
      if (sel(reg_addr, `PACHG_A_DIR)) begin
        dir_reg <= reg_wdata & `PACHG_IO_MASK;
      end
      if (sel(reg_addr, `PACHG_A_CHG_EN)) begin
        chg_en_reg <= reg_wdata & `PACHG_PIN_MASK;
      end
      if (sel(reg_addr, `PACHG_A_ANALOG)) begin
        analog_reg <= reg_wdata & `PACHG_ANALOG_MASK;
      end
      if (sel(reg_addr, `PACHG_A_INTCTL)) begin
        global_en_reg <= reg_wdata[`PACHG_BIT_GLOBAL_EN];
      end
      if (sel(reg_addr, `PACHG_A_INTCTL2)) begin
        pin_change_priority <= reg_wdata[`PACHG_BIT_PRIO];
      end
      if (sel(reg_addr, `PACHG_A_SERBUS)) begin
        serial_bus_module_enable <= reg_wdata[`PACHG_BIT_SERBUS];
      end
    end
  end

  // Pull-up state cleared only by power-on
  always @(posedge clk_sys) begin
    if (!por_n) begin
      pullup_reg <= `PACHG_PULLUP_RST;
      pu_dis_reg <= 1'b1;
    end else if (reg_wr && sel(reg_addr, `PACHG_A_PULLUP)) begin
      pullup_reg <= reg_wdata & `PACHG_PULLUP_MASK;
    end else if (reg_wr && sel(reg_addr, `PACHG_A_INTCTL2)) begin
      pu_dis_reg <= reg_wdata[`PACHG_BIT_PU_DIS];
    end
  end

  // Set wins over software clear
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_change_flag <= 1'b0;
    end else if (mismatch || second_port_mismatch) begin
      pin_change_flag <= 1'b1;
    end else if (flag_clear) begin
      pin_change_flag <= 1'b0;
    end
  end

  // Read data one cycle after the strobe
  always @* begin
    rdata_next = {WIDTH{1'b0}};
    case (reg_addr)
      `PACHG_A_PINS:    rdata_next = pins_sync & avail;
      `PACHG_A_LATCH:   rdata_next = latch_reg & {WIDTH{~osc_uses_pins}};
      `PACHG_A_DIR:     rdata_next = dir_reg & {WIDTH{~osc_uses_pins}};
      `PACHG_A_CHG_EN:  rdata_next = chg_en_reg;
      `PACHG_A_PULLUP:  rdata_next = pullup_reg;
      `PACHG_A_ANALOG:  rdata_next = analog_reg;
      `PACHG_A_INTCTL: begin
        rdata_next[`PACHG_BIT_GLOBAL_EN] = global_en_reg;
        rdata_next[`PACHG_BIT_FLAG]      = pin_change_flag;
      end
      `PACHG_A_INTCTL2: begin
        rdata_next[`PACHG_BIT_PU_DIS] = pu_dis_reg;
        rdata_next[`PACHG_BIT_PRIO]   = pin_change_priority;
      end
      `PACHG_A_SERBUS:  rdata_next[`PACHG_BIT_SERBUS] = serial_bus_module_enable;
      default:          rdata_next = {WIDTH{1'b0}};
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= {WIDTH{1'b0}};
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= {WIDTH{1'b0}};
    end
  end

  // Pin drivers; oscillator owns pins 5,4 when selected
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_out        <= {WIDTH{1'b0}};
      pin_oe         <= {WIDTH{1'b0}};
      pin_pullup     <= {WIDTH{1'b0}};
      pin4_analog    <= 1'b1;
      pin_change_irq <= 1'b0;
      wake_request   <= 1'b0;
    end else begin
      pin_out     <= latch_reg & `PACHG_IO_MASK;
      pin_oe      <= ~dir_reg & `PACHG_IO_MASK & {WIDTH{~osc_uses_pins}};
      pin_pullup  <= pullup_reg & {WIDTH{~pu_dis_reg}}
                     & ~(~dir_reg & `PACHG_IO_MASK);
      pin4_analog <= analog_reg[`PACHG_BIT_ANS_PIN4];
      pin_change_irq <= pin_change_flag & global_en_reg;
      wake_request   <= pin_change_flag & global_en_reg;
    end
  end
endmodule
`default_nettype wire

// *** tb/pachg_board.sv ***
`timescale 1ns/100ps
`default_nettype none
module pachg_board (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_drv,
  output logic      [7:0] pin_lvl
);
  // Board has weak pull-downs, so a floating pin without pull-up reads 0
  always_comb
    for (int i = 0; i < 8; i++)
      pin_lvl[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] : pin_pullup[i];
endmodule
`default_nettype wire

// *** tb/pachg_port_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module pachg_port_asserts #(
  parameter WIDTH = 8
) (
  input wire logic             clk_sys,
  input wire logic             rst_n,
  input wire logic [3:0]       reg_addr,
  input wire logic [WIDTH-1:0] reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [WIDTH-1:0] reg_rdata,
  input wire logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] pin_pullup,
  input wire logic             pin4_analog,
  input wire logic             osc_uses_pins,
  input wire logic             pin_change_flag,
  input wire logic             pin_change_irq,
  input wire logic             pin_change_priority,
  input wire logic             wake_request
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic clr_wr;
  assign clr_wr = reg_wr && reg_addr == 4'h6 && !reg_wdata[0];
  a_irq_needs_flag: assert property (pin_change_irq |-> $past(pin_change_flag))
    else $error("irq without flag");
  a_wake_irq: assert property (wake_request == pin_change_irq)
    else $error("wake differs from irq");
  a_oe_io_only: assert property ((pin_oe & 8'hcf) == 8'h00)
    else $error("driver on input-only pin");
  a_pullup_out_off: assert property ((pin_pullup & pin_oe) == 8'h00)
    else $error("pull-up on output pin");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  a_flag_clear_cause: assert property ($fell(pin_change_flag) |->
    $past(clr_wr) || $past(clr_wr, 2)) else $error("flag fell without clear");
  a_osc_no_drive: assert property (osc_uses_pins && $past(osc_uses_pins)
    && $past(osc_uses_pins, 2) |-> pin_oe == 8'h00) else $error("drive in osc mode");
  a_reset_defaults: assert property ($rose(rst_n) |-> pin_change_priority && pin4_analog)
    else $error("reset defaults wrong");
  cover property ($rose(pin_change_flag));
  cover property ($rose(pin_change_irq));
  cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind pachg_port pachg_port_asserts #(.WIDTH(WIDTH)) u_pachg_port_asserts (.clk_sys, .rst_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_oe, .pin_pullup, .pin4_analog,
  .osc_uses_pins, .pin_change_flag, .pin_change_irq, .pin_change_priority, .wake_request);
`default_nettype wire

// *** tb/pachg_port_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module pachg_port_test;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       por_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       move_instr = 1'b0;
  logic       external_reset_pin = 1'b0;
  logic       osc = 1'b0;
  logic       p2_mm = 1'b0;
  logic [7:0] ext_val = 8'h3b;
  logic [7:0] ext_drv = 8'hff;
  wire logic [7:0] reg_rdata, pin_out, pin_oe, pin_pullup, pin_lvl;
  wire logic       ana, flag, irq, prio, wake, sbe;
  int n_fail = 0;
  int compares = 0;
  always #12.5 clk_sys = ~clk_sys;
  pachg_port #(.WIDTH(8)) u_pachg_port (.clk_sys, .rst_n, .por_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .move_instr, .reg_rdata, .pin_in(pin_lvl), .pin_out, .pin_oe,
    .pin_pullup, .pin4_analog(ana), .master_clear_enable_cfg(external_reset_pin), .osc_uses_pins(osc),
    .second_port_mismatch(p2_mm), .pin_change_flag(flag), .pin_change_irq(irq),
    .pin_change_priority(prio), .wake_request(wake), .serial_bus_module_enable(sbe));
  pachg_board u_pachg_board (.pin_out, .pin_oe, .pin_pullup, .ext_val, .ext_drv, .pin_lvl);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Sync, flag and irq stages all settle well inside six cycles
  task automatic fl(input logic [7:0] e);
    repeat (6) @(posedge clk_sys);
    #1 chk({6'h00, flag, irq}, e);
    chk({7'h00, wake}, {7'h00, e[0]});
  endtask
  task automatic final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_fail++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    rd(4'h2, 8'h30);
    rd(4'h5, 8'h08);
    chk({7'h00, ana}, 8'h01);
    rd(4'h7, 8'h81);
    rd(4'hf, 8'h00);
    rd(4'h0, 8'h28);
    external_reset_pin <= 1'b1;
    rd(4'h0, 8'h20);
    external_reset_pin <= 1'b0;
    wr(4'h5, 8'h00);
    wr(4'h3, 8'h3b);
    rd(4'h0, 8'h3b);
    chk({7'h00, ana}, 8'h00);
    wr(4'h8, 8'h08);
    rd(4'h0, 8'h38);
    chk({7'h00, sbe}, 8'h01);
    rd(4'h8, 8'h08);
    wr(4'h8, 8'h00);
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h10);
    rd(4'h1, 8'h10);
    chk(pin_oe, 8'h30);
    chk(pin_out & 8'h30, 8'h10);
    rd(4'h0, 8'h1b);
    osc <= 1'b1;
    fl(8'h00);
    rd(4'h2, 8'h00);
    rd(4'h1, 8'h00);
    osc <= 1'b0;
    wr(4'h4, 8'h38);
    rd(4'h4, 8'h38);
    wr(4'h7, 8'h01);
    fl(8'h00);
    chk(pin_pullup, 8'h08);
    wr(4'h2, 8'h30);
    ext_drv <= 8'h00;
    fl(8'h02);
    chk(pin_pullup, 8'h38);
    rd(4'h0, 8'h38);
    ext_drv <= 8'hff;
    wr(4'h7, 8'h81);
    fl(8'h02);
    chk(pin_pullup, 8'h00);
    wr(4'h6, 8'h08);
    rd(4'h0, 8'h3b);
    wr(4'h6, 8'h08);
    fl(8'h00);
    ext_val <= 8'h33;
    fl(8'h03);
    wr(4'h6, 8'h08);
    fl(8'h03);
    rd(4'h0, 8'h33);
    wr(4'h6, 8'h08);
    fl(8'h00);
    wr(4'h3, 8'h33);
    ext_val <= 8'h3b;
    fl(8'h00);
    rd(4'h0, 8'h3b);
    wr(4'h3, 8'h3b);
    ext_val <= 8'h33;
    fl(8'h03);
    move_instr <= 1'b1;
    rd(4'h0, 8'h33);
    move_instr <= 1'b0;
    wr(4'h6, 8'h08);
    fl(8'h03);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(4'h3, 8'h3b);
    wr(4'h6, 8'h08);
    fl(8'h03);
    rd(4'h0, 8'h23);
    wr(4'h6, 8'h00);
    fl(8'h00);
    ext_val <= 8'h3b;
    fl(8'h02);
    rd(4'h0, 8'h2b);
    wr(4'h6, 8'h08);
    wr(4'h2, 8'h10);
    wr(4'h1, 8'h00);
    fl(8'h00);
    p2_mm <= 1'b1;
    fl(8'h03);
    rd(4'h6, 8'h09);
    p2_mm <= 1'b0;
    wr(4'h6, 8'h08);
    fl(8'h00);
    wr(4'h7, 8'h80);
    rd(4'h7, 8'h80);
    fl(8'h00);
    chk({7'h00, prio}, 8'h00);
    final_report;
  end
endmodule
`default_nettype wire
